// File: logic/pst_status_reg.sv
// Management status register with fixed abilities, fault flag and latching-low link status.
module pst_status_reg #(
    parameter bit AN_PRESENT = 1'b1,
    parameter int LINK_TIMER_CYCLES = pst_pkg::LINK_TIMER_CYCLES
) (
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic [4:0] REG_ADDR,
    input wire logic REG_RD,
    input wire logic REG_WR,
    input wire logic [15:0] REG_WDATA,
    input wire logic SYNC_STATUS,
    input wire logic AN_ENABLE,
    input wire logic AN_COMPLETE,
    input wire logic REMOTE_FAULT_EVT,
    input wire logic XCVR_RESET_DONE,
    output logic [15:0] REG_RDATA,
    output logic REG_RVALID
);

    logic sel_status;
    logic rd_status;
    logic wr_status;
    logic sync_held;
    logic an_ok;
    logic link_now;
    logic an_done_bit;
    logic fault_evt;
    logic link_stat_reg;
    logic link_stat_next;
    logic remote_fault_reg;
    logic remote_fault_next;
    logic [15:0] status_word;
    logic [15:0] rdata_next;
    logic rd_status_reg;
    logic [15:0] wdata_seen;

    // Decodes the register address and the read and write strobes.
    assign sel_status = (REG_ADDR == pst_pkg::PHY_STATUS_OFFSET);
    assign rd_status = REG_RD && sel_status;
    assign wr_status = REG_WR && !REG_RD && sel_status;

    // Write data is accepted and dropped, since every status bit is read only.
    assign wdata_seen = wr_status ? REG_WDATA : 16'h0000;

    // Holds sync for one link timer after a good link loses it.
    pst_link_holdoff #(
        .TIMER_CYCLES(LINK_TIMER_CYCLES)
    ) u_holdoff (
        .clk(SYS_CLK),
        .rst(SYS_RST),
        .sync_in(SYNC_STATUS),
        .link_good(link_now),
        .sync_held(sync_held)
    );

    // Negotiation counts as done when absent, disabled or finished.
    assign an_ok = !AN_PRESENT || !AN_ENABLE || AN_COMPLETE;

    // Live link state: held sync, negotiation done and transceiver out of reset.
    assign link_now = sync_held && an_ok && XCVR_RESET_DONE;

    // Negotiation complete bit only carries meaning when negotiation is built in.
    assign an_done_bit = AN_PRESENT ? AN_COMPLETE : 1'b0;

    // Remote fault events only exist with negotiation built in.
    assign fault_evt = AN_PRESENT && REMOTE_FAULT_EVT;

    // Link status: a read reloads the live state, otherwise a loss latches zero.
    always_comb begin
        link_stat_next = link_stat_reg;
        if (rd_status) begin
            link_stat_next = link_now;
        end else if (!link_now) begin
            link_stat_next = 1'b0;
        end
    end

    // Link status flip-flop, zero after reset.
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            link_stat_reg <= pst_pkg::LINK_STAT_RESET;
        end else begin
            link_stat_reg <= link_stat_next;
        end
    end

    // Remote fault: a new event wins over the clear that a read makes.
    always_comb begin
        remote_fault_next = remote_fault_reg;
        if (fault_evt) begin
            remote_fault_next = 1'b1;
        end else if (rd_status) begin
            remote_fault_next = 1'b0;
        end
    end

    // Remote fault flip-flop.
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            remote_fault_reg <= pst_pkg::REMOTE_FAULT_RESET;
        end else begin
            remote_fault_reg <= remote_fault_next;
        end
    end

    // Assembles the word as it reads now, before any clear from this read.
    always_comb begin
        status_word = 16'h0000;
        status_word[pst_pkg::ABIL_HI_POS:pst_pkg::ABIL_LO_POS] = 7'h00;
        status_word[pst_pkg::EXT_STATUS_POS] = 1'b1;
        status_word[pst_pkg::UNIDIR_POS] = 1'b1;
        status_word[pst_pkg::PREAMBLE_SUPP_POS] = 1'b1;
        status_word[pst_pkg::AN_DONE_POS] = an_done_bit;
        status_word[pst_pkg::REMOTE_FAULT_POS] = remote_fault_reg;
        status_word[pst_pkg::AN_ABILITY_POS] = AN_PRESENT;
        status_word[pst_pkg::LINK_STAT_POS] = link_stat_reg;
        status_word[pst_pkg::JABBER_POS] = 1'b0;
        status_word[pst_pkg::EXT_CAP_POS] = 1'b0;
    end

    // Read data for the next cycle; other offsets read as zero.
    always_comb begin
        rdata_next = pst_pkg::RDATA_RESET;
        if (rd_status) begin
            rdata_next = status_word;
        end
    end

    // Read data register, loaded on every read and held until the next one.
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            REG_RDATA <= pst_pkg::RDATA_RESET;
        end else if (REG_RD) begin
            REG_RDATA <= rdata_next;
        end
    end

    // Read valid pulse one cycle after each read strobe.
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            REG_RVALID <= 1'b0;
        end else begin
            REG_RVALID <= REG_RD;
        end
    end

    // Remembers whether the answer in flight belongs to the status register.
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            rd_status_reg <= 1'b0;
        end else begin
            rd_status_reg <= rd_status;
        end
    end

    // The old ability bits of a status answer are zero.
    a_abil_zero: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        (REG_RVALID && rd_status_reg) |-> (REG_RDATA[15:9] == 7'h00))
        else $error("status ability bits 15 to 9 not zero");

    // Extended status, unidirectional and preamble bits read one.
    a_ext_status: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        (REG_RVALID && rd_status_reg) |-> REG_RDATA[8])
        else $error("extended status bit not one");

    a_unidir_one: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        (REG_RVALID && rd_status_reg) |-> REG_RDATA[7])
        else $error("unidirectional ability bit not one");

    a_preamble_one: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        (REG_RVALID && rd_status_reg) |-> REG_RDATA[6])
        else $error("preamble suppression bit not one");

    // Negotiation complete reported as it stood in the read cycle.
    a_an_done: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        rd_status |=> (REG_RDATA[5] == $past(an_done_bit)))
        else $error("negotiation complete bit does not follow the input");

    // A fault event is held until read, and a read without event clears it.
    a_fault_set: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        fault_evt |=> remote_fault_reg)
        else $error("remote fault not captured");

    a_fault_clear: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        (rd_status && !fault_evt) |=> !remote_fault_reg)
        else $error("remote fault not cleared by read");

    // A read of a set fault flag reports it before the clear takes effect.
    a_fault_report: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        (rd_status && remote_fault_reg) |=> REG_RDATA[4])
        else $error("set remote fault not reported by the read");

    // Negotiation ability reads one when negotiation is built in.
    a_an_ability: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        (REG_RVALID && rd_status_reg) |-> (REG_RDATA[3] == AN_PRESENT))
        else $error("negotiation ability bit wrong");

    // Link loss latches zero, and a read reloads the live state.
    a_link_latch: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        (!link_now && !rd_status) |=> !link_stat_reg)
        else $error("link status did not latch low");

    a_link_reload: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        rd_status |=> (link_stat_reg == $past(link_now)))
        else $error("read did not reload link status");

    // A latched zero only rises again through a read.
    a_link_stays: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        (!rd_status && !link_stat_reg) |=> !link_stat_reg)
        else $error("link status rose without a read");

    // The read answer carries the latched link bit as it stood before the reload.
    a_link_answer: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        rd_status |=> (REG_RDATA[2] == $past(link_stat_reg)))
        else $error("read answer does not show the latched link bit");

    // The live link needs the transceiver out of reset.
    a_link_xcvr: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        (!XCVR_RESET_DONE && !rd_status) |=> !link_stat_reg)
        else $error("link status high while transceiver in reset");

    // Jabber and extended capability bits read zero.
    a_low_zero: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        (REG_RVALID && rd_status_reg) |-> (REG_RDATA[1:0] == 2'b00))
        else $error("status bits 1 and 0 not zero");

    // A write alone never clears the fault flag.
    a_write_none: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        (wr_status && remote_fault_reg) |=> remote_fault_reg)
        else $error("write cleared the remote fault flag");

    // A write never disturbs a link bit that is up with the link still good.
    a_write_link: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        (wr_status && link_stat_reg && link_now) |=> link_stat_reg)
        else $error("write changed the link status bit");

endmodule

// File: logic/pst_pkg.sv
// Package with the offsets, field positions, reset values and timing counts of the status register.
package pst_pkg;

    // Register address width and the offset of the status register.
    localparam int REG_ADDR_W = 5;
    localparam logic [4:0] PHY_STATUS_OFFSET = 5'h01;
    localparam int REG_DATA_W = 16;

    // Field positions inside the status register.
    localparam int ABIL_HI_POS = 15;
    localparam int ABIL_LO_POS = 9;
    localparam int EXT_STATUS_POS = 8;
    localparam int UNIDIR_POS = 7;
    localparam int PREAMBLE_SUPP_POS = 6;
    localparam int AN_DONE_POS = 5;
    localparam int REMOTE_FAULT_POS = 4;
    localparam int AN_ABILITY_POS = 3;
    localparam int LINK_STAT_POS = 2;
    localparam int JABBER_POS = 1;
    localparam int EXT_CAP_POS = 0;

    // Reset values of the stored bits.
    localparam logic LINK_STAT_RESET = 1'b0;
    localparam logic REMOTE_FAULT_RESET = 1'b0;
    localparam logic [15:0] RDATA_RESET = 16'h0000;

    // Link timer hold-off: the time in microseconds and its count of clock cycles.
    localparam int CLK_MHZ = 100;
    localparam int LINK_TIMER_US = 10000;
    localparam int LINK_TIMER_CYCLES = LINK_TIMER_US * CLK_MHZ;

    // States of the sync hold-off tracker, one-hot.
    typedef enum logic [2:0] {
        PST_DOWN = 3'b001,
        PST_UP   = 3'b010,
        PST_HOLD = 3'b100
    } pst_hold_state_t;

endpackage

// File: logic/pst_link_holdoff.sv
// Sync hold-off tracker that keeps a good link's sync valid for one link timer after loss.
module pst_link_holdoff #(
    parameter int TIMER_CYCLES = pst_pkg::LINK_TIMER_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic sync_in,
    input wire logic link_good,
    output logic sync_held
);

    localparam int CNT_W = $clog2(TIMER_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TIMER_CYCLES - 1);

    pst_pkg::pst_hold_state_t state_reg;
    pst_pkg::pst_hold_state_t state_next;
    logic [CNT_W-1:0] cnt_reg;

    // Next state: a good link that loses sync enters the hold, which ends on timeout.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            pst_pkg::PST_DOWN: begin
                if (sync_in && link_good) begin
                    state_next = pst_pkg::PST_UP;
                end
            end
            pst_pkg::PST_UP: begin
                if (!sync_in) begin
                    state_next = pst_pkg::PST_HOLD;
                end
            end
            pst_pkg::PST_HOLD: begin
                if (sync_in) begin
                    state_next = pst_pkg::PST_UP;
                end else if (cnt_reg == CNT_LAST) begin
                    state_next = pst_pkg::PST_DOWN;
                end
            end
            default: begin
                state_next = pst_pkg::PST_DOWN;
            end
        endcase
    end

    // State register.
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= pst_pkg::PST_DOWN;
        end else begin
            state_reg <= state_next;
        end
    end

    // Counts the cycles of sync loss spent in the hold.
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_reg <= '0;
        end else if (state_reg == pst_pkg::PST_HOLD && !sync_in) begin
            cnt_reg <= cnt_reg + 1'b1;
        end else begin
            cnt_reg <= '0;
        end
    end

    // Sync seen by the link logic: live sync, or a good link whose loss is still timed.
    // Tracking from the up state as well covers the first cycle of a loss, before the hold.
    assign sync_held = sync_in || (state_reg != pst_pkg::PST_DOWN);

    // A good link that loses sync keeps its held sync in that cycle and the next.
    a_hold_start: assert property (@(posedge clk) disable iff (rst)
        (state_reg == pst_pkg::PST_UP && !sync_in) |-> sync_held ##1 sync_held)
        else $error("held sync dropped at the start of a sync loss");

    // The hold ends exactly after the full timer when sync stays lost.
    a_hold_expire: assert property (@(posedge clk) disable iff (rst)
        (state_reg == pst_pkg::PST_HOLD && !sync_in && cnt_reg == CNT_LAST)
        |=> (state_reg == pst_pkg::PST_DOWN))
        else $error("hold did not end when the link timer ran out");

endmodule

// File: tb/pst_mgmt_model.sv
// Management station model that reads and writes the status register port.
module pst_mgmt_model (
    input wire logic clk,
    output logic rd,
    output logic wr,
    output logic [4:0] addr,
    output logic [15:0] wdata,
    input wire logic [15:0] rdata,
    input wire logic rvalid
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle strobes from time zero.
    initial begin
        rd = 1'b0;
        wr = 1'b0;
        addr = 5'h1e;
        wdata = 16'h5a5a;
    end

    // One read strobe, then a bounded wait for the answer; no answer leaves d unknown.
    task automatic read(input logic [4:0] a, output logic [15:0] d);
        int n;
        n = 0;
        d = 16'hxxxx;
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
        while (n < 4) begin
            @(posedge clk);
            if (rvalid === 1'b1) begin
                d = rdata;
                break;
            end
            n++;
        end
    endtask

    // One write strobe; released lines show the inverse of their last value.
    task automatic write(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask

    // A zero link bit may be history, so the station reads once more to learn the present state.
    task automatic read_link(output logic [15:0] first, output logic [15:0] second);
        read(pst_pkg::PHY_STATUS_OFFSET, first);
        second = first;
        if (first[pst_pkg::LINK_STAT_POS] !== 1'b1) begin
            read(pst_pkg::PHY_STATUS_OFFSET, second);
        end
    endtask
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the management status register.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int TMR = 20;
    logic clk, rst, rd, wr, sync, an_en, an_done, rf_evt, xcvr, rvalid;
    logic [4:0] addr;
    logic [15:0] wdata, rdata, d1, d2;
    int n_fail = 0;
    int total_checks = 0;
    int cycles = 0;

    pst_status_reg #(.AN_PRESENT(1'b1), .LINK_TIMER_CYCLES(TMR)) i_dut (
        .SYS_CLK(clk), .SYS_RST(rst), .REG_ADDR(addr), .REG_RD(rd), .REG_WR(wr),
        .REG_WDATA(wdata), .SYNC_STATUS(sync), .AN_ENABLE(an_en), .AN_COMPLETE(an_done),
        .REMOTE_FAULT_EVT(rf_evt), .XCVR_RESET_DONE(xcvr), .REG_RDATA(rdata),
        .REG_RVALID(rvalid));

    pst_mgmt_model i_mgmt (.clk(clk), .rd(rd), .wr(wr), .addr(addr), .wdata(wdata),
        .rdata(rdata), .rvalid(rvalid));

    // Clock of 10 ns period.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Expected status word from the three live fields; the rest are fixed.
    function automatic logic [15:0] ew(input logic an, input logic f, input logic l);
        return {7'h00, 3'b111, an, f, 1'b1, l, 2'b00};
    endfunction

    // Prints the counts and the verdict, then ends the run.
    task automatic results();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Compares one read word.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: read %h, wanted %h", $time, got, exp);
        end
    endtask

    // Reads the status register and compares it.
    task automatic rd_chk(input logic [15:0] exp);
        logic [15:0] d;
        i_mgmt.read(pst_pkg::PHY_STATUS_OFFSET, d);
        chk(d, exp);
    endtask

    // Waits a number of clock edges.
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Cuts a hang short.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_fail++;
            $display("unexpected at %0t: run too long", $time);
            results();
        end
    end

    // Main sequence.
    initial begin
        rst = 1'b1;
        sync = 1'b0;
        an_en = 1'b1;
        an_done = 1'b0;
        rf_evt = 1'b0;
        xcvr = 1'b0;
        wt(4);
        rst <= 1'b0;
        rd_chk(ew(1'b0, 1'b0, 1'b0));
        sync <= 1'b1;
        xcvr <= 1'b1;
        wt(3);
        rd_chk(ew(1'b0, 1'b0, 1'b0));
        rd_chk(ew(1'b0, 1'b0, 1'b0));
        an_done <= 1'b1;
        wt(3);
        i_mgmt.read_link(d1, d2);
        chk(d1, ew(1'b1, 1'b0, 1'b0));
        chk(d2, ew(1'b1, 1'b0, 1'b1));
        // A one-cycle transceiver drop, a fault event, then writes that must change nothing.
        xcvr <= 1'b0;
        rf_evt <= 1'b1;
        @(posedge clk);
        xcvr <= 1'b1;
        rf_evt <= 1'b0;
        wt(3);
        i_mgmt.write(pst_pkg::PHY_STATUS_OFFSET, 16'h0000);
        i_mgmt.write(pst_pkg::PHY_STATUS_OFFSET, 16'hffff);
        rd_chk(ew(1'b1, 1'b1, 1'b0));
        rd_chk(ew(1'b1, 1'b0, 1'b1));
        an_en <= 1'b0;
        an_done <= 1'b0;
        wt(3);
        rd_chk(ew(1'b0, 1'b0, 1'b1));
        // Sync loss: link holds for the timer, then drops.
        sync <= 1'b0;
        wt(TMR - 6);
        rd_chk(ew(1'b0, 1'b0, 1'b1));
        wt(TMR);
        i_mgmt.read_link(d1, d2);
        chk(d1, ew(1'b0, 1'b0, 1'b0));
        chk(d2, ew(1'b0, 1'b0, 1'b0));
        sync <= 1'b1;
        wt(3);
        i_mgmt.read_link(d1, d2);
        chk(d1, ew(1'b0, 1'b0, 1'b0));
        chk(d2, ew(1'b0, 1'b0, 1'b1));
        // A loss shorter than the timer leaves the link bit up.
        sync <= 1'b0;
        wt(5);
        sync <= 1'b1;
        wt(3);
        rd_chk(ew(1'b0, 1'b0, 1'b1));
        results();
    end
endmodule
